// file: nbh_host.sv
`timescale 1ns/1ps
`default_nettype none
module nbh_host (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Request port
    input wire logic reqValid,
    output logic reqReady,
    input wire nbh_pkg::nbh_req_s req,
    input wire logic writeProtectAllow,
    // Write data stream
    input wire logic wrValid,
    output logic wrReady,
    input wire logic [7:0] wrData,
    // Read data stream
    output logic rdValid,
    output logic [7:0] rdData,
    // Status
    output logic memBusy,
    output logic opDone,
    // Memory pins
    output logic chipSelN,
    output logic cmdLatch,
    output logic addrLatch,
    output logic writeStrobeN,
    output logic readStrobeN,
    output logic protectN,
    output logic [7:0] ioOut,
    output logic ioOe,
    input wire logic [7:0] ioIn,
    input wire logic readyBusyN
);
    import nbh_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b011,
        ST_DONE = 3'b100
    } nbh_state_e;

    nbh_state_e state_ff, nxt_state;
    nbh_req_s cur_ff;
    nbh_pins_s pins_ff, nxt_pins;
    logic [3:0] tmr_ff;
    logic [15:0] cnt_ff;
    logic [7:0] ioOut_ff, nxt_ioOut;
    logic ioOe_ff;
    logic rdValid_ff;
    logic [7:0] rdData_ff;
    logic opDone_ff;
    logic reqReady_ff;
    logic memBusy_ff;
    logic [7:0] ioSync1_ff, ioSync2_ff;
    logic rbSync1_ff, rbSync2_ff;

    // FIFO between write stream and the bus
    logic fifoValid;
    logic fifoPop;
    logic [7:0] fifoData;
    nbh_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) nbh_fifo_inst (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .inValid(wrValid),
        .inReady(wrReady),
        .inData(wrData),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    // Address byte select; reserved high bits driven low
    function automatic logic [7:0] addrByte(input logic [12:0] col, input logic [16:0] row, input logic [2:0] idx);
        unique case (idx)
            3'd0: addrByte = col[7:0];
            3'd1: addrByte = {3'b000, col[12:8]};
            3'd2: addrByte = row[7:0];                      // page + block low bits
            3'd3: addrByte = row[15:8];
            default: addrByte = {7'h00, row[16]};           // block bit 11 stays low
        endcase
    endfunction

    // Column clamp: spare region access keeps bits 10:7 low
    wire [12:0] colSafe = cur_ff.col[12] ? (cur_ff.col & 13'h187f) : cur_ff.col;
    wire [2:0] addrIdx = cnt_ff[2:0];
    wire isWrite = cur_ff.op == NBH_OP_WRDATA;
    wire isRead = cur_ff.op == NBH_OP_RDDATA;
    wire isAddr = cur_ff.op == NBH_OP_ADDR;
    wire lastBeat = isAddr ? (cnt_ff == 16'(ADDR_CYCLES - 1)) : (cnt_ff + 16'd1 >= cur_ff.len);
    wire tmrDone = tmr_ff == 4'd0;
    // Data phase waits on FIFO; stall keeps write strobe high
    wire dataStall = isWrite && !fifoValid;
    wire idleStart = state_ff == ST_IDLE && reqValid && reqReady_ff;
    assign fifoPop = state_ff == ST_SETUP && isWrite && fifoValid;
    assign reqReady = reqReady_ff;
    wire [7:0] beatByte = (cur_ff.op == NBH_OP_CMD) ? cur_ff.cmd :
                          isAddr ? addrByte(colSafe, cur_ff.row, addrIdx) : fifoData;

    // Next-state and pin decode
    always_comb begin
        nxt_state = state_ff;
        nxt_pins = pins_ff;
        nxt_ioOut = ioOut_ff;
        unique case (state_ff)
            ST_IDLE: begin
                // Idle: strobes high, protect follows writeProtectAllow; high keeps any busy program/erase safe
                nxt_pins.writeStrobeN = 1'b1;
                nxt_pins.readStrobeN = 1'b1;
                nxt_pins.protectN = writeProtectAllow;
                if (idleStart) begin
                    nxt_state = ST_SETUP;
                    nxt_pins.chipSelN = 1'b0;
                    nxt_pins.cmdLatch = req.op == NBH_OP_CMD;
                    nxt_pins.addrLatch = req.op == NBH_OP_ADDR;
                    // Program/erase setup and data input need protect high
                    nxt_pins.protectN = writeProtectAllow | req.modify | (req.op == NBH_OP_WRDATA);
                end
            end
            ST_SETUP: begin
                if (!dataStall) begin
                    nxt_state = ST_LOW;
                    nxt_ioOut = beatByte;
                    // Strobe low time well above 5 ns so no pulse looks like a glitch
                    if (isRead) begin
                        nxt_pins.readStrobeN = 1'b0;
                    end else begin
                        nxt_pins.writeStrobeN = 1'b0;
                    end
                end
            end
            ST_LOW: begin
                if (tmrDone) begin
                    nxt_state = ST_HIGH;
                    nxt_pins.writeStrobeN = 1'b1;            // latch on rising edge
                    nxt_pins.readStrobeN = 1'b1;
                end
            end
            ST_HIGH: begin
                if (tmrDone) begin
                    nxt_state = lastBeat ? ST_DONE : ST_SETUP;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_pins.cmdLatch = 1'b0;
                nxt_pins.addrLatch = 1'b0;
                nxt_pins.chipSelN = 1'b1;                    // standby
            end
        endcase
    end

    // Phase timer and beat counter
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tmr_ff <= 4'd0;
            cnt_ff <= LEN_RESET;
        end else if (state_ff == ST_SETUP) begin
            tmr_ff <= STROBE_LOW_CYC - 4'd1;
        end else if (state_ff == ST_LOW && tmrDone) begin
            tmr_ff <= STROBE_HIGH_CYC - 4'd1;
        end else if (!tmrDone) begin
            tmr_ff <= tmr_ff - 4'd1;
        end
        if (rstn && state_ff == ST_IDLE) begin
            cnt_ff <= LEN_RESET;
        end else if (rstn && state_ff == ST_HIGH && tmrDone) begin
            cnt_ff <= cnt_ff + 16'd1;
        end
    end

    // State, request and pin registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            cur_ff <= '0;
            pins_ff <= 6'b100110;
            ioOut_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            pins_ff <= nxt_pins;
            ioOut_ff <= nxt_ioOut;
            if (idleStart) begin
                cur_ff <= req;
            end
        end
    end

    // Bus drive: only during command, address and data-in beats
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ioOe_ff <= 1'b0;
        end else begin
            ioOe_ff <= (nxt_state == ST_LOW || nxt_state == ST_HIGH) && !isRead && state_ff != ST_IDLE;
        end
    end

    // Two-stage sync of pins from the memory
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ioSync1_ff <= 8'h00;
            ioSync2_ff <= 8'h00;
            rbSync1_ff <= 1'b0;
            rbSync2_ff <= 1'b0;
        end else begin
            ioSync1_ff <= ioIn;
            ioSync2_ff <= ioSync1_ff;
            rbSync1_ff <= readyBusyN;
            rbSync2_ff <= rbSync1_ff;
        end
    end

    // Ready and busy come from flops; they lag the synced pin by one edge, which only delays a start
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            reqReady_ff <= 1'b0;
            memBusy_ff <= 1'b1;
        end else begin
            reqReady_ff <= nxt_state == ST_IDLE && rbSync2_ff;
            memBusy_ff <= !rbSync2_ff;
        end
    end

    // Read capture just before the strobe rises; sync lag fits in low time
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rdValid_ff <= 1'b0;
            rdData_ff <= 8'h00;
            opDone_ff <= 1'b0;
        end else begin
            rdValid_ff <= isRead && state_ff == ST_LOW && tmrDone;
            if (isRead && state_ff == ST_LOW && tmrDone) begin
                rdData_ff <= ioSync2_ff;
            end
            opDone_ff <= state_ff == ST_DONE;
        end
    end

    assign chipSelN = pins_ff.chipSelN;
    assign cmdLatch = pins_ff.cmdLatch;
    assign addrLatch = pins_ff.addrLatch;
    assign writeStrobeN = pins_ff.writeStrobeN;
    assign readStrobeN = pins_ff.readStrobeN;
    assign protectN = pins_ff.protectN;
    assign ioOut = ioOut_ff;
    assign ioOe = ioOe_ff;
    assign rdValid = rdValid_ff;
    assign rdData = rdData_ff;
    assign opDone = opDone_ff;
    assign memBusy = memBusy_ff;
endmodule
`default_nettype wire

// file: nbh_pkg.sv
// What this block does
// - Page 4KB+256 spare, 64 pages, 4 partials
// - Five address bytes: two column, three row
// - Column bit 12 set forces bits 10:7 low
// - Command byte on write strobe, command latch high
// - Five address bytes, address latch high
// - Protect input high for program/erase setup
// - Data bytes with both latches low, protect high
// - Read strobe toggles shift out bytes
// - Strobes held high during read busy
// - Protect follows writeProtectAllow during program/erase busy
package nbh_pkg;
    localparam int PAGE_MAIN_BYTES = 4096;
    localparam int PAGE_SPARE_BYTES = 256;
    localparam int PAGES_PER_BLOCK = 64;
    localparam int PARTIAL_PROGRAM_COUNT = 4;
    localparam int PARTIAL_BYTES = 1024;
    localparam int ADDR_CYCLES = 5;
    // Strobe half-period timing at 200 MHz
    localparam int CLK_PERIOD_NS = 5;
    localparam int STROBE_LOW_NS = 20;
    localparam int STROBE_HIGH_NS = 20;
    localparam int GLITCH_NS = 5;
    localparam logic [3:0] STROBE_LOW_CYC = 4'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] STROBE_HIGH_CYC = 4'((STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 8;
    localparam logic [12:0] COL_RESET = 13'h0000;
    localparam logic [16:0] ROW_RESET = 17'h00000;
    localparam logic [15:0] LEN_RESET = 16'h0000;

    typedef enum logic [1:0] {
        NBH_OP_CMD = 2'b00,
        NBH_OP_ADDR = 2'b01,
        NBH_OP_WRDATA = 2'b10,
        NBH_OP_RDDATA = 2'b11
    } nbh_op_e;

    // Host request: one bus phase
    typedef struct packed {
        nbh_op_e op;
        logic [7:0] cmd;
        logic modify;       // Program/erase setup needs protect high
        logic [12:0] col;
        logic [16:0] row;   // {block[10:0], page[5:0]}
        logic [15:0] len;   // Data byte count
    } nbh_req_s;

    // Pin outputs toward the memory
    typedef struct packed {
        logic chipSelN;
        logic cmdLatch;
        logic addrLatch;
        logic writeStrobeN;
        logic readStrobeN;
        logic protectN;
    } nbh_pins_s;
endpackage

// file: nbh_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module nbh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_ff;
    logic [AW:0] rdPtr_ff;
    logic inReady_ff;
    logic [AW:0] nxt_wrPtr;
    logic [AW:0] nxt_rdPtr;
    wire doWr = inValid && inReady_ff;
    wire doRd = outValid && outReady;
    // Next pointers feed both the pointer flops and the registered ready
    assign nxt_wrPtr = wrPtr_ff + (AW+1)'(doWr);
    assign nxt_rdPtr = rdPtr_ff + (AW+1)'(doRd);
    assign inReady = inReady_ff;
    assign outValid = wrPtr_ff != rdPtr_ff;
    assign outData = mem[rdPtr_ff[AW-1:0]];

    // Storage has no reset, pointers do
    always_ff @(posedge sys_clk) begin
        if (doWr) begin
            mem[wrPtr_ff[AW-1:0]] <= inData;
        end
    end

    // Pointer update
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            inReady_ff <= 1'b1;
        end else begin
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
            // Full when pointers differ only in the wrap bit; a flop here keeps the port free of logic
            inReady_ff <= (nxt_wrPtr ^ nxt_rdPtr) != {1'b1, {AW{1'b0}}};
        end
    end
endmodule
`default_nettype wire

// file: nbh_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module nbh_host_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Status
    input wire logic reqReady,
    input wire logic writeProtectAllow,
    input wire logic memBusy,
    // Memory pins
    input wire logic chipSelN,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic writeStrobeN,
    input wire logic readStrobeN,
    input wire logic protectN,
    input wire logic ioOe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Qualifiers must already stand when the write strobe rises or the read strobe falls
    property p_cmdIn; $rose(writeStrobeN) && cmdLatch |-> !chipSelN && !addrLatch && readStrobeN; endproperty
    a_cmdIn: assert property (p_cmdIn) else $error("command strobe badly qualified");
    property p_addrIn; $rose(writeStrobeN) && addrLatch |-> !chipSelN && !cmdLatch && readStrobeN; endproperty
    a_addrIn: assert property (p_addrIn) else $error("address strobe badly qualified");
    property p_dataIn; $rose(writeStrobeN) && !cmdLatch && !addrLatch |-> !chipSelN && readStrobeN && protectN; endproperty
    a_dataIn: assert property (p_dataIn) else $error("data strobe badly qualified");
    property p_rdOut; $fell(readStrobeN) |-> !chipSelN && !cmdLatch && !addrLatch && writeStrobeN; endproperty
    a_rdOut: assert property (p_rdOut) else $error("read strobe badly qualified");
    // Four low cycles keep every pulse far above the glitch width
    property p_wrLow; $fell(writeStrobeN) |-> (!writeStrobeN) [*4] ##1 writeStrobeN; endproperty
    a_wrLow: assert property (p_wrLow) else $error("write strobe low width wrong");
    property p_rdLow; $fell(readStrobeN) |-> (!readStrobeN) [*4] ##1 readStrobeN; endproperty
    a_rdLow: assert property (p_rdLow) else $error("read strobe low width wrong");
    // Idle host passes the protect level straight through
    property p_protect; reqReady && $past(reqReady) && $past(rstn) |-> protectN == $past(writeProtectAllow); endproperty
    a_protect: assert property (p_protect) else $error("protect pin not following");
    property p_busy; memBusy |-> writeStrobeN && readStrobeN; endproperty
    a_busy: assert property (p_busy) else $error("strobe moved while busy");
    property p_ready; reqReady |-> !memBusy; endproperty
    a_ready: assert property (p_ready) else $error("request taken while busy");
    // Host drives the byte across the latching edge, and never while the memory drives
    property p_busDrive; $rose(writeStrobeN) |-> ioOe && $past(ioOe); endproperty
    a_busDrive: assert property (p_busDrive) else $error("bus not driven at latch edge");
    property p_busRelease; !readStrobeN |-> !ioOe; endproperty
    a_busRelease: assert property (p_busRelease) else $error("bus driven during read");
endmodule
`default_nettype wire

// file: nbh_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module nbh_flash_model (
    // Host pins
    input wire logic chipSelN,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic writeStrobeN,
    input wire logic readStrobeN,
    input wire logic protectN,
    input wire logic [7:0] ioOut,
    // Device outputs
    output logic [7:0] ioIn,
    output logic readyBusyN
);
    import nbh_pkg::*;
    logic [7:0] mem [int];
    logic [7:0] stage [int];
    logic [7:0] addrByte [5];
    logic [7:0] dout = 8'h5a;
    int cnt = 0;
    int col = 0;
    int busyNs = 400;
    realtime fallAt = 0;
    initial readyBusyN = 1'b1;
    // Block bit 11 has no storage, so it is dropped from the row
    wire [16:0] rowIn = {addrByte[4][0], addrByte[3], addrByte[2]};
    // Released bus shows the inverse of the last byte, never a stale copy
    assign ioIn = (!chipSelN && !readStrobeN) ? dout : ~dout;
    always @(negedge writeStrobeN) fallAt = $realtime;
    // Capture on write strobe rise; short pulses count as glitches
    always @(posedge writeStrobeN) begin
        if (!chipSelN && readStrobeN && $realtime - fallAt >= GLITCH_NS) begin
            if (cmdLatch && !addrLatch) begin
                cnt = 0;
                if (ioOut == 8'h80) stage.delete();
                if (ioOut == 8'h10 && protectN) begin
                    foreach (stage[k]) mem[k] = stage[k];
                    readyBusyN = 1'b0;
                end
                if (ioOut == 8'h30) readyBusyN = 1'b0;
            end else if (addrLatch && !cmdLatch && cnt < ADDR_CYCLES) begin
                addrByte[cnt] = ioOut;
                cnt++;
                col = {addrByte[1][4:0], addrByte[0]};
            end else if (!addrLatch && !cmdLatch && protectN) begin
                stage[rowIn * 8192 + col] = ioOut;
                col++;
            end
        end
    end
    // Busy time, then ready again
    always @(negedge readyBusyN) #(busyNs) readyBusyN = 1'b1;
    // Each read strobe fall presents the next byte
    always @(negedge readStrobeN) begin
        if (!chipSelN) begin
            dout = mem.exists(rowIn * 8192 + col) ? mem[rowIn * 8192 + col] : 8'hff;
            col++;
        end
    end
endmodule
`default_nettype wire

// file: nbh_host_test.sv
`timescale 1ns/1ps
`default_nettype none
module nbh_host_test;
    import nbh_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic reqValid = 1'b0;
    nbh_req_s req = '0;
    logic writeProtectAllow = 1'b1;
    logic wrValid = 1'b0;
    logic [7:0] wrData = 8'h00;
    wire reqReady, wrReady, rdValid, memBusy, opDone, chipSelN, cmdLatch, addrLatch;
    wire writeStrobeN, readStrobeN, protectN, ioOe, readyBusyN;
    wire [7:0] rdData, ioOut, ioIn;
    int bad_count = 0;
    int comparisons = 0;
    int seed = 32'hb0b6;
    logic [7:0] wq[$];
    logic [7:0] rq[$];
    logic [7:0] keep[$];
    logic [12:0] col;
    logic [16:0] row;
    logic [39:0] ab;
    always #2.5 sys_clk = ~sys_clk;
    nbh_host nbh_host_inst (.sys_clk(sys_clk), .rstn(rstn), .reqValid(reqValid), .reqReady(reqReady), .req(req),
        .writeProtectAllow(writeProtectAllow), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
        .rdValid(rdValid), .rdData(rdData), .memBusy(memBusy), .opDone(opDone), .chipSelN(chipSelN),
        .cmdLatch(cmdLatch), .addrLatch(addrLatch), .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN),
        .protectN(protectN), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn), .readyBusyN(readyBusyN));
    nbh_flash_model nbh_flash_model_inst (.chipSelN(chipSelN), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
        .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN), .protectN(protectN), .ioOut(ioOut),
        .ioIn(ioIn), .readyBusyN(readyBusyN));
    // Read bytes stand for one cycle only
    always @(posedge sys_clk) if (rdValid === 1'b1) rq.push_back(rdData);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Spent bound counts as a mismatch and ends the run
    task automatic limit(input int n);
        if (n >= 4000) begin
            bad_count++;
            conclude();
        end
    endtask
    task automatic doReq(input nbh_op_e op, input logic [7:0] cmd, input logic modify, input logic [15:0] len);
        int n;
        req <= '{op, cmd, modify, col, row, len};
        reqValid <= 1'b1;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (reqReady !== 1'b1 && n < 4000);
        limit(n);
        reqValid <= 1'b0;
        n = 0;
        while (opDone !== 1'b1 && n < 4000) begin @(posedge sys_clk); n++; end
        limit(n);
    endtask
    task automatic push(input int count, input int gap);
        int n;
        logic [7:0] b;
        for (int i = 0; i < count; i++) begin
            b = 8'($random(seed));
            wq.push_back(b);
            wrData <= b;
            wrValid <= 1'b1;
            n = 0;
            do begin @(posedge sys_clk); n++; end while (wrReady !== 1'b1 && n < 4000);
            limit(n);
            if (gap > 0) begin
                wrValid <= 1'b0;
                repeat (gap) @(posedge sys_clk);
            end
        end
        wrValid <= 1'b0;
    endtask
    task automatic readBack();
        doReq(NBH_OP_CMD, 8'h00, 1'b0, 16'h0000);
        doReq(NBH_OP_ADDR, 8'h00, 1'b0, 16'h0000);
        doReq(NBH_OP_CMD, 8'h30, 1'b0, 16'h0000);
        rq.delete();
        doReq(NBH_OP_RDDATA, 8'h00, 1'b0, 16'h0014);
        repeat (2) @(posedge sys_clk);
        check(rq.size(), 20);
        foreach (wq[i]) check(rq[i], wq[i]);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        // Program: full buffer refuses, then a slow fill adds the last 4 bytes before the buffered 16 run out
        col = 13'h0100 + 13'($random(seed) & 32'h3ff);
        row = 17'($random(seed) & 32'hffff);
        ab = {7'h00, row[16], row[15:8], row[7:0], 3'h0, col[12:8], col[7:0]};
        doReq(NBH_OP_CMD, 8'h80, 1'b1, 16'h0000);
        doReq(NBH_OP_ADDR, 8'h00, 1'b1, 16'h0000);
        for (int i = 0; i < 5; i++) check(nbh_flash_model_inst.addrByte[i], ab[8*i +: 8]);
        push(16, 0);
        @(posedge sys_clk);
        wrValid <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check(wrReady, 1'b0);
        wrValid <= 1'b0;
        fork
            doReq(NBH_OP_WRDATA, 8'h00, 1'b1, 16'h0014);
            begin repeat (40) @(posedge sys_clk); push(4, 30); end
        join
        doReq(NBH_OP_CMD, 8'h10, 1'b1, 16'h0000);
        foreach (wq[i]) check(nbh_flash_model_inst.mem[row * 8192 + col + i], wq[i]);
        $display("program test done");
        nbh_flash_model_inst.busyNs = 2000;
        readBack();
        $display("read test done");
        // Protect dropped before confirm: array keeps the old bytes
        keep = wq;
        wq.delete();
        doReq(NBH_OP_CMD, 8'h80, 1'b1, 16'h0000);
        doReq(NBH_OP_ADDR, 8'h00, 1'b1, 16'h0000);
        fork
            doReq(NBH_OP_WRDATA, 8'h00, 1'b1, 16'h0014);
            push(20, 0);
        join
        writeProtectAllow <= 1'b0;
        repeat (3) @(posedge sys_clk);
        // Confirm goes out unmarked, so the host passes the low protect level through
        doReq(NBH_OP_CMD, 8'h10, 1'b0, 16'h0000);
        check(protectN, 1'b0);
        writeProtectAllow <= 1'b1;
        repeat (3) @(posedge sys_clk);
        wq = keep;
        readBack();
        $display("protect test done");
        // Column bit 12 set clears bits 10:7
        col = 13'h1780;
        doReq(NBH_OP_CMD, 8'h00, 1'b0, 16'h0000);
        doReq(NBH_OP_ADDR, 8'h00, 1'b0, 16'h0000);
        check(nbh_flash_model_inst.addrByte[1], 8'h10);
        check(nbh_flash_model_inst.addrByte[0], 8'h00);
        $display("column test done");
        conclude();
    end
endmodule
bind nbh_host nbh_host_asserts nbh_host_asserts_inst (.sys_clk(sys_clk), .rstn(rstn), .reqReady(reqReady),
    .writeProtectAllow(writeProtectAllow), .memBusy(memBusy), .chipSelN(chipSelN), .cmdLatch(cmdLatch),
    .addrLatch(addrLatch), .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN), .protectN(protectN),
    .ioOe(ioOe));
`default_nettype wire
